// ===== jrxcfg_defs.vh
// constants for the link configuration block
// Functional notes
// - modes 0..3 are single link only: four converters, lanes 8/8/4/2, S 1/2/1/1, F 1/2/2/4
// - modes 4,5,6,7,9,10 allow one or two links with their own M, L, S, F
// - lane rate equals twenty times data rate times M over L
// - high density is one exactly when F equals one; both ends agree
// - converter resolution and bits per sample are both sixteen
// - two-link setting runs two separately resettable links with identical parameters
// - scrambling setting tells the receiver whether to descramble
// - link select picks which link later per-link writes reach
// - lane enable and deskew masks are two to the L minus one
// - each lane powers off when its bit in the unused-lane register is one
// - checksum method zero sums fields, one sums packed registers; must match transmitter
// - field checksum is low byte of L-1,M-1,K-1,N-1,Np-1,S-1,SCR,HD,subclass,version
// - register checksum is low byte of the sum of packed registers 0x450..0x45A
// - converter power-down mask follows M and two-link setting table
// - one converter per link in two-link mode sets the routing bit
// - pair clock power-down field bits 7:6 is one when DAC2 and DAC3 are off
// - sampling: oversample 0/1/2, full rate 0/0/1, half rate 1/0/0
// - subclass one uses SYSREF; subclass zero needs lanes within one multiframe
// - processing clock is lane rate over forty; delays count its cycles
// - frames per processing clock is four over F; clocks per multiframe is K over that
// - variable and fixed delays release all lanes in the same multiframe cycle
`ifndef JRXCFG_DEFS_VH
`define JRXCFG_DEFS_VH
`define JRXCFG_ADDR_W 12
`define JRXCFG_OFS_CLK_PWR 12'h080
`define JRXCFG_OFS_LANE_PWR 12'h201
`define JRXCFG_OFS_MODE 12'h210
`define JRXCFG_OFS_LINK 12'h211
`define JRXCFG_OFS_CDR 12'h212
`define JRXCFG_OFS_DLY 12'h213
`define JRXCFG_OFS_CSUM_RX 12'h214
`define JRXCFG_OFS_STATUS 12'h215
`define JRXCFG_OFS_MASKS 12'h216
`define JRXCFG_OFS_PACK_LO 12'h450
`define JRXCFG_OFS_PACK_HI 12'h45A
`define JRXCFG_RST_BYTE 8'h00
`define JRXCFG_RST_MODE 4'h0
`define JRXCFG_PCLK_RATIO 40
`define JRXCFG_FRAME_OCTETS 4
`define JRXCFG_RES_BITS 16
`define JRXCFG_CLK_PD_BIT_HI 7
`define JRXCFG_CLK_PD_BIT_LO 6
`define JRXCFG_CLK_PD_ON 2'h1
`define JRXCFG_CLK_PD_OFF 2'h0
`endif

// ===== jrxcfg_mode_rom.v
// mode table: converters, lanes, samples and octets per frame for each mode
module jrxcfg_mode_rom (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // lookup
    input wire [3:0] mode_i,
    output reg [2:0] conv_o,
    output reg [3:0] lanes_o,
    output reg [1:0] samp_o,
    output reg [2:0] oct_o,
    output reg dual_ok_o,
    output reg legal_o
);
    reg [2:0] next_conv;
    reg [3:0] next_lanes;
    reg [1:0] next_samp;
    reg [2:0] next_oct;
    reg next_dual_ok;
    reg next_legal;

    always @* begin
        next_legal = 1'b1;
        next_dual_ok = 1'b1;
        case (mode_i)
            4'h0: begin next_conv = 3'h4; next_lanes = 4'h8; next_samp = 2'h1; next_oct = 3'h1; next_dual_ok = 1'b0; end
            4'h1: begin next_conv = 3'h4; next_lanes = 4'h8; next_samp = 2'h2; next_oct = 3'h2; next_dual_ok = 1'b0; end
            4'h2: begin next_conv = 3'h4; next_lanes = 4'h4; next_samp = 2'h1; next_oct = 3'h2; next_dual_ok = 1'b0; end
            4'h3: begin next_conv = 3'h4; next_lanes = 4'h2; next_samp = 2'h1; next_oct = 3'h4; next_dual_ok = 1'b0; end
            4'h4: begin next_conv = 3'h2; next_lanes = 4'h4; next_samp = 2'h1; next_oct = 3'h1; end
            4'h5: begin next_conv = 3'h2; next_lanes = 4'h4; next_samp = 2'h2; next_oct = 3'h2; end
            4'h6: begin next_conv = 3'h2; next_lanes = 4'h2; next_samp = 2'h1; next_oct = 3'h2; end
            4'h7: begin next_conv = 3'h2; next_lanes = 4'h1; next_samp = 2'h1; next_oct = 3'h4; end
            4'h9: begin next_conv = 3'h1; next_lanes = 4'h2; next_samp = 2'h1; next_oct = 3'h1; end
            4'hA: begin next_conv = 3'h1; next_lanes = 4'h1; next_samp = 2'h1; next_oct = 3'h2; end
            default: begin
                // unlisted codes fall back to mode 0 values but are flagged
                next_conv = 3'h4;
                next_lanes = 4'h8;
                next_samp = 2'h1;
                next_oct = 3'h1;
                next_dual_ok = 1'b0;
                next_legal = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_o <= 3'h4;
            lanes_o <= 4'h8;
            samp_o <= 2'h1;
            oct_o <= 3'h1;
            dual_ok_o <= 1'b0;
            legal_o <= 1'b1;
        end else begin
            conv_o <= next_conv;
            lanes_o <= next_lanes;
            samp_o <= next_samp;
            oct_o <= next_oct;
            dual_ok_o <= next_dual_ok;
            legal_o <= next_legal;
        end
    end
endmodule // jrxcfg_mode_rom

// ===== jrxcfg_top.v
// link configuration registers and derived settings for the lane receiver
`include "jrxcfg_defs.vh"
module jrxcfg_top #(
    parameter JESD_VERSION = 3'h1
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // received first-lane checksum from the deframer
    input wire [7:0] rx_checksum_i,
    input wire rx_checksum_vld_i,
    // link controls
    output reg [1:0] link_enable_o,
    output reg [1:0] link_reset_o,
    output reg descramble_o,
    output reg high_density_flag_o,
    output reg [7:0] lane_enable_o,
    output reg [7:0] lane_deskew_o,
    output reg [7:0] lane_power_off_mask_o,
    // converter controls
    output reg [3:0] converter_power_down_mask_o,
    output reg route_a_o,
    output reg [1:0] pair_clock_power_down_o,
    // serdes clocking
    output reg cdr_halfrate_o,
    output reg cdr_oversample_o,
    output reg [1:0] serdes_pll_divider_o,
    // latency
    output reg [3:0] variable_delay_window_o,
    output reg [4:0] fixed_delay_setting_o,
    output reg [2:0] frames_per_proc_clock_o,
    output reg [5:0] proc_clocks_per_multiframe_o,
    output reg sysref_use_o,
    // status
    output reg cfg_error_o,
    output reg checksum_mismatch_o
);
    // stored registers
    reg [7:0] clk_pwr;
    reg [3:0] mode;
    reg k_is_32;
    reg two_link_select;
    reg link_select;
    reg scrambling;
    reg subclass;
    reg checksum_method;
    reg [1:0] cdr_mode;
    reg [1:0] link_rst_req;
    reg [3:0] var_dly [0:1];
    reg [4:0] fix_dly [0:1];
    reg [7:0] lane_pwr;
    reg [7:0] pack [0:10];
    reg mismatch;
    integer i;
    integer j;

    wire [2:0] conv;
    wire [3:0] lanes;
    wire [1:0] samp;
    wire [2:0] oct;
    wire dual_ok;
    wire legal;

    // per-mode M and L keep lane rate at twenty times data rate times M over L
    jrxcfg_mode_rom u_rom (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .mode_i(mode),
        .conv_o(conv),
        .lanes_o(lanes),
        .samp_o(samp),
        .oct_o(oct),
        .dual_ok_o(dual_ok),
        .legal_o(legal)
    );

    wire hd = (oct == 3'h1);
    wire [5:0] k_val = k_is_32 ? 6'h20 : 6'h10;
    // K of 16 is illegal where F is one (modes 0, 4, 9)
    wire k_bad = hd & ~k_is_32;
    wire dual_bad = two_link_select & ~dual_ok;
    wire addr_pack = (reg_addr_i >= `JRXCFG_OFS_PACK_LO) && (reg_addr_i <= `JRXCFG_OFS_PACK_HI);
    wire [3:0] pack_idx = reg_addr_i[3:0];

    // field checksum, N-1 and Np-1 are both fifteen
    localparam integer RES_M1 = `JRXCFG_RES_BITS - 1;
    wire [7:0] n_m1 = RES_M1[7:0];
    wire [7:0] sum_fields = {4'h0, lanes} - 8'h01 + {5'h00, conv} - 8'h01 + {2'h0, k_val} - 8'h01
        + n_m1 + n_m1 + {6'h00, samp} - 8'h01 + {7'h00, scrambling} + {7'h00, hd} + {7'h00, subclass}
        + {5'h00, JESD_VERSION[2:0]};
    reg [7:0] sum_regs;
    always @* begin
        sum_regs = 8'h00;
        for (i = 0; i < 11; i = i + 1) begin
            sum_regs = sum_regs + pack[i];
        end
    end
    wire [7:0] csum_exp = checksum_method ? sum_regs : sum_fields;

    reg [2:0] next_fpc;
    always @* begin
        case (oct)
            3'h1: next_fpc = 3'h4;
            3'h2: next_fpc = 3'h2;
            default: next_fpc = 3'h1;
        endcase
    end
    wire [5:0] next_ppm = (next_fpc == 3'h4) ? {2'h0, k_val[5:2]} :
        (next_fpc == 3'h2) ? {1'b0, k_val[5:1]} : k_val;

    reg [3:0] next_pd;
    always @* begin
        case (conv)
            3'h1: next_pd = two_link_select ? 4'h6 : 4'h7;
            3'h2: next_pd = two_link_select ? 4'h0 : 4'h3;
            default: next_pd = 4'h0;
        endcase
    end

    // register writes
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_pwr <= `JRXCFG_RST_BYTE;
            mode <= `JRXCFG_RST_MODE;
            k_is_32 <= 1'b1;
            two_link_select <= 1'b0;
            link_select <= 1'b0;
            scrambling <= 1'b0;
            subclass <= 1'b0;
            checksum_method <= 1'b0;
            cdr_mode <= 2'h0;
            link_rst_req <= 2'h0;
            lane_pwr <= `JRXCFG_RST_BYTE;
            // own loop index so the checksum adder keeps i to itself
            for (j = 0; j < 2; j = j + 1) begin
                var_dly[j] <= 4'h0;
                fix_dly[j] <= 5'h00;
            end
            for (j = 0; j < 11; j = j + 1) begin
                pack[j] <= `JRXCFG_RST_BYTE;
            end
        end else begin
            // link reset requests are one-cycle pulses
            link_rst_req <= 2'h0;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `JRXCFG_OFS_CLK_PWR: clk_pwr <= reg_wdata_i;
                    `JRXCFG_OFS_LANE_PWR: lane_pwr <= reg_wdata_i;
                    `JRXCFG_OFS_MODE: begin
                        mode <= reg_wdata_i[3:0];
                        k_is_32 <= reg_wdata_i[4];
                        scrambling <= reg_wdata_i[5];
                        subclass <= reg_wdata_i[6];
                        checksum_method <= reg_wdata_i[7];
                    end
                    `JRXCFG_OFS_LINK: begin
                        two_link_select <= reg_wdata_i[0];
                        link_select <= reg_wdata_i[1];
                        link_rst_req <= reg_wdata_i[3:2];
                    end
                    `JRXCFG_OFS_CDR: cdr_mode <= reg_wdata_i[1:0];
                    `JRXCFG_OFS_DLY: begin
                        // delays land in the link chosen by link select
                        var_dly[link_select] <= reg_wdata_i[3:0];
                    end
                    `JRXCFG_OFS_CSUM_RX: fix_dly[link_select] <= reg_wdata_i[4:0];
                    default: begin
                        if (addr_pack) begin
                            pack[pack_idx] <= reg_wdata_i;
                        end
                    end
                endcase
            end
        end
    end

    // read mux and derived outputs
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
            link_enable_o <= 2'h0;
            link_reset_o <= 2'h0;
            descramble_o <= 1'b0;
            high_density_flag_o <= 1'b0;
            lane_enable_o <= 8'h00;
            lane_deskew_o <= 8'h00;
            lane_power_off_mask_o <= 8'h00;
            converter_power_down_mask_o <= 4'h0;
            route_a_o <= 1'b0;
            pair_clock_power_down_o <= 2'h0;
            cdr_halfrate_o <= 1'b0;
            cdr_oversample_o <= 1'b1;
            serdes_pll_divider_o <= 2'h2;
            variable_delay_window_o <= 4'h0;
            fixed_delay_setting_o <= 5'h00;
            frames_per_proc_clock_o <= 3'h4;
            proc_clocks_per_multiframe_o <= 6'h08;
            sysref_use_o <= 1'b0;
            cfg_error_o <= 1'b0;
            checksum_mismatch_o <= 1'b0;
            mismatch <= 1'b0;
        end else begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `JRXCFG_OFS_CLK_PWR: reg_rdata_o <= clk_pwr;
                    `JRXCFG_OFS_LANE_PWR: reg_rdata_o <= lane_pwr;
                    `JRXCFG_OFS_MODE: reg_rdata_o <= {checksum_method, subclass, scrambling, k_is_32, mode};
                    `JRXCFG_OFS_LINK: reg_rdata_o <= {6'h00, link_select, two_link_select};
                    `JRXCFG_OFS_CDR: reg_rdata_o <= {6'h00, cdr_mode};
                    `JRXCFG_OFS_DLY: reg_rdata_o <= {4'h0, var_dly[link_select]};
                    `JRXCFG_OFS_CSUM_RX: reg_rdata_o <= {3'h0, fix_dly[link_select]};
                    `JRXCFG_OFS_STATUS: reg_rdata_o <= {4'h0, mismatch, k_bad, dual_bad, ~legal};
                    `JRXCFG_OFS_MASKS: reg_rdata_o <= csum_exp;
                    default: reg_rdata_o <= addr_pack ? pack[pack_idx] : 8'h00;
                endcase
            end
            link_enable_o <= two_link_select ? 2'h3 : 2'h1;
            link_reset_o <= link_rst_req;
            descramble_o <= scrambling;
            high_density_flag_o <= hd;
            // thermometer mask of L ones; lane count is at most eight
            lane_enable_o <= (lanes == 4'h8) ? 8'hFF : ((8'h01 << lanes[2:0]) - 8'h01);
            lane_deskew_o <= (lanes == 4'h8) ? 8'hFF : ((8'h01 << lanes[2:0]) - 8'h01);
            lane_power_off_mask_o <= lane_pwr;
            converter_power_down_mask_o <= next_pd;
            route_a_o <= (conv == 3'h1) & two_link_select;
            // mask is written DAC0 first, so DAC2 and DAC3 are the low two bits
            pair_clock_power_down_o <= (next_pd[1:0] == 2'h3) ? `JRXCFG_CLK_PD_ON : `JRXCFG_CLK_PD_OFF;
            case (cdr_mode)
                2'h1: begin
                    cdr_halfrate_o <= 1'b0;
                    cdr_oversample_o <= 1'b0;
                    serdes_pll_divider_o <= 2'h1;
                end
                2'h2: begin
                    cdr_halfrate_o <= 1'b1;
                    cdr_oversample_o <= 1'b0;
                    serdes_pll_divider_o <= 2'h0;
                end
                default: begin
                    cdr_halfrate_o <= 1'b0;
                    cdr_oversample_o <= 1'b1;
                    serdes_pll_divider_o <= 2'h2;
                end
            endcase
            // each link stores its own delay pair, but only link 0's pair drives the output
            variable_delay_window_o <= var_dly[0];
            fixed_delay_setting_o <= fix_dly[0];
            frames_per_proc_clock_o <= next_fpc;
            proc_clocks_per_multiframe_o <= next_ppm;
            sysref_use_o <= subclass;
            cfg_error_o <= ~legal | k_bad | dual_bad;
            // sticky until a new checksum compares equal
            if (rx_checksum_vld_i) begin
                mismatch <= (rx_checksum_i != csum_exp);
                checksum_mismatch_o <= (rx_checksum_i != csum_exp);
            end
        end
    end
endmodule // jrxcfg_top

// ===== jrxcfg_tx_model.sv
// transmitter model that sends the first-lane checksum its own settings imply
module jrxcfg_tx_model (
    input wire logic core_clk_i,
    output logic [7:0] rx_checksum_o,
    output logic rx_checksum_vld_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rx_checksum_o = 8'hA5;
        rx_checksum_vld_o = 1'b0;
    end
    task automatic send(input [7:0] l, m, k, s, input scr, hd, sub, method, input [7:0] psum, input bad);
        logic [7:0] sum;
        // N and bits per sample are both sixteen; link version is one
        sum = method ? psum : (l - 8'h01) + (m - 8'h01) + (k - 8'h01) + 8'h0F + 8'h0F + (s - 8'h01) + scr + hd + sub + 8'h01;
        if (bad) sum = ~sum;
        @(posedge core_clk_i);
        rx_checksum_o <= sum;
        rx_checksum_vld_o <= 1'b1;
        @(posedge core_clk_i);
        rx_checksum_vld_o <= 1'b0;
        // unqualified data never keeps the last value
        rx_checksum_o <= ~sum;
    endtask
endmodule // jrxcfg_tx_model

// ===== jrxcfg_properties.sv
// concurrent checks on the link configuration block ports
module jrxcfg_properties (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire reg_wr_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire rx_checksum_vld_i,
    input wire [1:0] link_enable_o,
    input wire [1:0] link_reset_o,
    input wire descramble_o,
    input wire high_density_flag_o,
    input wire [7:0] lane_enable_o,
    input wire [7:0] lane_deskew_o,
    input wire [7:0] lane_power_off_mask_o,
    input wire [3:0] converter_power_down_mask_o,
    input wire route_a_o,
    input wire [1:0] pair_clock_power_down_o,
    input wire cdr_halfrate_o,
    input wire cdr_oversample_o,
    input wire [1:0] serdes_pll_divider_o,
    input wire [2:0] frames_per_proc_clock_o,
    input wire [5:0] proc_clocks_per_multiframe_o,
    input wire sysref_use_o,
    input wire checksum_mismatch_o
);
    // derived outputs trail writes, so cross-output relations wait until reset has settled
    reg [1:0] settle;
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) settle <= 2'h0;
        else if (settle != 2'h3) settle <= settle + 2'h1;
    end
    wire ok = settle == 2'h3;
    wire [3:0] pdm = converter_power_down_mask_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // stored field, then output register: outputs show a write two edges later
    a_link_enable: assert property (s_wr(12'h211) |-> ##2 link_enable_o == ($past(reg_wdata_i[0], 2) ? 2'h3 : 2'h1))
        else $error("link enable wrong after link write");
    a_link_reset: assert property (link_reset_o != 2'h0 |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 12'h211
        && $past(reg_wdata_i[3:2], 2) == link_reset_o)
        else $error("link reset pulse without its write");
    a_lane_power: assert property (s_wr(12'h201) |-> ##2 lane_power_off_mask_o == $past(reg_wdata_i, 2))
        else $error("lane power mask not taken");
    a_scr_sub: assert property (s_wr(12'h210) |-> ##2 descramble_o == $past(reg_wdata_i[5], 2)
        && sysref_use_o == $past(reg_wdata_i[6], 2))
        else $error("scrambling or subclass not taken");
    a_cdr_mode: assert property (s_wr(12'h212) ##0 reg_wdata_i < 8'h03 |-> ##2
        {cdr_halfrate_o, cdr_oversample_o, serdes_pll_divider_o} ==
        ($past(reg_wdata_i, 2) == 8'h00 ? 4'h6 : $past(reg_wdata_i, 2) == 8'h01 ? 4'h1 : 4'h8))
        else $error("sampling mode outputs wrong");
    a_hd_factor: assert property (ok |-> high_density_flag_o == (frames_per_proc_clock_o == 3'h4))
        else $error("high density disagrees with octets per frame");
    a_lane_masks: assert property (ok |-> lane_enable_o == lane_deskew_o && ((({1'b0, lane_enable_o} + 9'h001) & {1'b0, lane_enable_o}) == 9'h000))
        else $error("lane masks not thermometer coded");
    a_mf_clocks: assert property (ok |-> ({3'h0, proc_clocks_per_multiframe_o} * {6'h00, frames_per_proc_clock_o}) inside {9'h010, 9'h020})
        else $error("clocks per multiframe disagree with K");
    a_pair_clock: assert property (ok && $stable(pdm) |-> pair_clock_power_down_o == (pdm[1:0] == 2'h3 ? 2'h1 : 2'h0))
        else $error("pair clock power-down wrong");
    a_route_bit: assert property (ok && $stable(pdm) |-> !route_a_o || pdm == 4'h6)
        else $error("routing bit outside one converter two-link");
    a_csum_hold: assert property (ok && !$past(rx_checksum_vld_i) |-> $stable(checksum_mismatch_o))
        else $error("mismatch changed without a checksum");
endmodule // jrxcfg_properties
bind jrxcfg_top jrxcfg_properties chk_u (.core_clk_i, .rst_b_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .rx_checksum_vld_i, .link_enable_o, .link_reset_o, .descramble_o, .high_density_flag_o, .lane_enable_o,
    .lane_deskew_o, .lane_power_off_mask_o, .converter_power_down_mask_o, .route_a_o, .pair_clock_power_down_o,
    .cdr_halfrate_o, .cdr_oversample_o, .serdes_pll_divider_o, .frames_per_proc_clock_o,
    .proc_clocks_per_multiframe_o, .sysref_use_o, .checksum_mismatch_o);

// ===== jrxcfg_top_tb.sv
// self-checking bench for the link configuration block
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, s); end end
module jrxcfg_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, vld;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00, rdata, csum, lane_en, lane_dsk, lane_off;
    logic [1:0] link_en, link_rst, pair_pd, pll_div;
    logic [3:0] pdm, vwin;
    logic [4:0] fdel;
    logic [2:0] fac;
    logic [5:0] ppm;
    logic descr, hd, route, half, ovs, sysref, cerr, mism;
    int failures = 0, checked = 0;
    int modes[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10};
    jrxcfg_tx_model tx_u (.core_clk_i(core_clk_i), .rx_checksum_o(csum), .rx_checksum_vld_o(vld));
    jrxcfg_top dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .rx_checksum_i(csum),
        .rx_checksum_vld_i(vld), .link_enable_o(link_en), .link_reset_o(link_rst), .descramble_o(descr),
        .high_density_flag_o(hd), .lane_enable_o(lane_en), .lane_deskew_o(lane_dsk),
        .lane_power_off_mask_o(lane_off), .converter_power_down_mask_o(pdm), .route_a_o(route),
        .pair_clock_power_down_o(pair_pd), .cdr_halfrate_o(half), .cdr_oversample_o(ovs),
        .serdes_pll_divider_o(pll_div), .variable_delay_window_o(vwin), .fixed_delay_setting_o(fdel),
        .frames_per_proc_clock_o(fac), .proc_clocks_per_multiframe_o(ppm), .sysref_use_o(sysref),
        .cfg_error_o(cerr), .checksum_mismatch_o(mism));
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task results;
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task rd(input [11:0] a, input [7:0] e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK("read data", e, rdata)
    endtask
    task cfg(input [7:0] md, input dual);
        wr(12'h211, {7'h00, dual});
        wr(12'h210, md);
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    // packed {M, L, F} per mode; S reaches the ports only through the field checksum
    function automatic [11:0] tbl(input int md);
        case (md)
            0: tbl = 12'h481; 1: tbl = 12'h482; 2: tbl = 12'h442; 3: tbl = 12'h424;
            4: tbl = 12'h241; 5: tbl = 12'h242; 6: tbl = 12'h222; 7: tbl = 12'h214;
            9: tbl = 12'h121; default: tbl = 12'h112;
        endcase
    endfunction
    task t_modes;
        logic [11:0] e;
        logic [3:0] em;
        for (int i = 0; i < 10; i++) begin
            e = tbl(modes[i]);
            for (int d = 0; d <= (modes[i] > 3); d++) begin
                cfg({4'h1, modes[i][3:0]}, d[0]);
                em = d ? (e[11:8] == 4'h2 ? 4'h0 : 4'h6) : (e[11:8] == 4'h4 ? 4'h0 : e[11:8] == 4'h2 ? 4'h3 : 4'h7);
                `CHK("lane enable", 8'((9'h001 << e[7:4]) - 9'h001), lane_en)
                `CHK("lane deskew", 8'((9'h001 << e[7:4]) - 9'h001), lane_dsk)
                `CHK("high density", e[3:0] == 4'h1, hd)
                `CHK("frames per clock", 3'(4 / e[3:0]), fac)
                `CHK("clocks per multiframe", 6'(8 * e[3:0]), ppm)
                `CHK("dac power-down", em, pdm)
                `CHK("pair clock", (em[1:0] == 2'h3) ? 2'h1 : 2'h0, pair_pd)
                `CHK("routing bit", d == 1 && e[11:8] == 4'h1, route)
                `CHK("link enable", d ? 2'h3 : 2'h1, link_en)
                `CHK("config error", 1'b0, cerr)
            end
        end
    endtask
    task t_illegal;
        cfg(8'h18, 1'b0);
        `CHK("mode 8 error", 1'b1, cerr)
        cfg(8'h00, 1'b0);
        `CHK("mode 0 K16 error", 1'b1, cerr)
        cfg(8'h11, 1'b1);
        `CHK("mode 1 two-link error", 1'b1, cerr)
        cfg(8'h05, 1'b0);
        `CHK("mode 5 K16 error", 1'b0, cerr)
        `CHK("mode 5 K16 clocks", 6'h08, ppm)
    endtask
    task t_regs;
        rd(12'h201, 8'h00);
        rd(12'h080, 8'h00);
        wr(12'h201, 8'hCC);
        @(posedge core_clk_i);
        #1;
        `CHK("lane power off", 8'hCC, lane_off)
        rd(12'h201, 8'hCC);
        wr(12'h080, 8'h40);
        rd(12'h080, 8'h40);
        wr(12'h7FF, 8'h5A);
        rd(12'h7FF, 8'h00);
        for (int v = 0; v < 3; v++) begin
            wr(12'h212, 8'(v));
            @(posedge core_clk_i);
            #1;
            `CHK("sampling mode", v == 0 ? 4'h6 : v == 1 ? 4'h1 : 4'h8, {half, ovs, pll_div})
        end
    endtask
    task t_links;
        wr(12'h211, 8'h00);
        wr(12'h213, 8'h05);
        wr(12'h214, 8'h09);
        wr(12'h211, 8'h02);
        wr(12'h213, 8'h07);
        wr(12'h214, 8'h11);
        rd(12'h213, 8'h07);
        `CHK("variable delay", 4'h5, vwin)
        `CHK("fixed delay", 5'h09, fdel)
        wr(12'h211, 8'h09);
        @(posedge core_clk_i);
        #1;
        `CHK("link reset pulse", 2'h2, link_rst)
        @(posedge core_clk_i);
        #1;
        `CHK("link reset ends", 2'h0, link_rst)
        wr(12'h211, 8'h00);
        rd(12'h213, 8'h05);
    endtask
    task t_csum;
        cfg(8'h74, 1'b0);
        `CHK("descramble", 1'b1, descr)
        `CHK("sysref use", 1'b1, sysref)
        rd(12'h216, 8'h45);
        tx_u.send(4, 2, 32, 1, 1, 1, 1, 0, 8'h00, 0);
        #1;
        `CHK("field checksum match", 1'b0, mism)
        tx_u.send(4, 2, 32, 1, 1, 1, 1, 0, 8'h00, 1);
        #1;
        `CHK("field checksum bad", 1'b1, mism)
        for (int i = 0; i < 11; i++) wr(12'h450 + 12'(i), 8'(i + 1));
        cfg(8'hF4, 1'b0);
        rd(12'h216, 8'h42);
        tx_u.send(4, 2, 32, 1, 1, 1, 1, 1, 8'h42, 0);
        #1;
        `CHK("register checksum match", 1'b0, mism)
    endtask
    initial begin
        #(25 * 20000);
        failures++;
        results;
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1;
        `CHK("mode 0 lanes", 8'hFF, lane_en)
        `CHK("mode 0 clocks", 6'h08, ppm)
        t_regs;
        t_modes;
        t_illegal;
        t_links;
        t_csum;
        results;
    end
endmodule // jrxcfg_top_tb
